/* include/tmc_regs.vh */
// Register map, field positions, reset values and timing counts
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TMC_ADDR_CTRL      8'hC8
`define TMC_ADDR_RELOAD_LO 8'hCA
`define TMC_ADDR_RELOAD_HI 8'hCB
`define TMC_ADDR_COUNT_LO  8'hCC
`define TMC_ADDR_COUNT_HI  8'hCD

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TMC_BIT_HIGH_FLAG  3'd7
`define TMC_BIT_LOW_FLAG   3'd6
`define TMC_BIT_LOW_IRQEN  3'd5
`define TMC_BIT_CAPTURE    3'd4
`define TMC_BIT_SPLIT      3'd3
`define TMC_BIT_RUN        3'd2
`define TMC_BIT_SRC_HI     3'd1
`define TMC_BIT_SRC_LO     3'd0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TMC_RST_CTRL       8'h00
`define TMC_RST_BYTE       8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TMC_SYS_DIV        4'd12
`define TMC_RTC_DIV        3'd0

`endif

/* design/tmc_sync.v */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none

module tmc_sync (
  // Clock and reset
  input  wire core_clk,
  input  wire arst_n,
  // Data
  input  wire din,
  output wire dout
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule
`default_nettype wire

/* design/tmc_srcgen.v */
// Source enables: system clock/12, rtc/8 and comparator edge pulses
`timescale 1ns/1ns
`default_nettype none

module tmc_srcgen (
  // Clock and reset
  input  wire core_clk,
  input  wire arst_n,
  // Asynchronous sources
  input  wire rtc_clk_in,
  input  wire cmp0_in,
  // Enables
  output reg  div12_pulse_ff,
  output reg  rtc8_pulse_ff,
  output reg  cmp_pulse_ff
);

`include "tmc_regs.vh"

  wire       rtc_s;
  wire       cmp_s;
  reg        rtc_d_ff;
  reg        cmp_d_ff;
  reg  [3:0] div12_ff;
  reg  [2:0] rtc8_ff;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  tmc_sync u_sync_rtc (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .din      (rtc_clk_in),
    .dout     (rtc_s)
  );

  tmc_sync u_sync_cmp (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .din      (cmp0_in),
    .dout     (cmp_s)
  );

  // ----------------------------------------
  // Dividers and edge detection
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div12_ff       <= 4'h0;
      rtc8_ff        <= 3'h0;
      rtc_d_ff       <= 1'b0;
      cmp_d_ff       <= 1'b0;
      div12_pulse_ff <= 1'b0;
      rtc8_pulse_ff  <= 1'b0;
      cmp_pulse_ff   <= 1'b0;
    end else begin
      rtc_d_ff <= rtc_s;
      cmp_d_ff <= cmp_s;
      if (div12_ff == `TMC_SYS_DIV - 4'd1) begin
        div12_ff       <= 4'h0;
        div12_pulse_ff <= 1'b1;
      end else begin
        div12_ff       <= div12_ff + 4'd1;
        div12_pulse_ff <= 1'b0;
      end
      rtc8_pulse_ff <= 1'b0;
      if (rtc_s && !rtc_d_ff) begin
        rtc8_ff <= rtc8_ff + 3'd1;
        if (rtc8_ff == 3'h7) begin
          rtc8_pulse_ff <= 1'b1;
        end
      end
      cmp_pulse_ff <= cmp_s && !cmp_d_ff;
    end
  end

endmodule
`default_nettype wire

/* design/tmc_timer.v */
// Timer 2 control register, counter, reload and capture logic
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - High flag sets when upper count byte wraps FF to 00.
// - In 16-bit mode counting sets high flag only on full FFFF wrap; a capture also sets it.
// - Timer interrupt enabled: request interrupt when high flag sets.
// - Hardware never clears overflow flags; software clears them.
// - Low flag sets on every low-byte wrap, any mode.
// - Low irq enable plus timer irq enable: interrupt on low overflow.
// - In 16-bit mode capture enable selects capture mode instead of plain reload.
// - Split bit: two 8-bit reload timers; clear: one 16-bit timer.
// - In 16-bit mode timer counts only while run control is 1.
// - In split mode run gates only upper byte; lower always runs.
// - Source select decodes external clock and capture trigger.
// - Shared external clock; per-byte pick chooses it or system clock.
// - External sources are synchronised before use.
// - Capture copies count into reload pair and sets high flag.
// - 16-bit overflow reloads count from reload pair.
module tmc_timer (
  // Clock and reset
  input  wire       core_clk,
  input  wire       arst_n,
  // Special-function register port
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_bit_wr,
  input  wire [2:0] sfr_bit_sel,
  input  wire       sfr_bit_val,
  output reg  [7:0] sfr_rdata_ff,
  // Clock picks and interrupt enable
  input  wire       high_byte_clock_pick,
  input  wire       low_byte_clock_pick,
  input  wire       timer_irq_enable,
  // Asynchronous sources
  input  wire       rtc_clk_in,
  input  wire       cmp0_in,
  // Interrupt request
  output reg        timer_irq_ff
);

`include "tmc_regs.vh"

  reg  [7:0] timer_control_reg_ff;
  reg  [7:0] count_low_ff;
  reg  [7:0] count_high_ff;
  reg  [7:0] reload_low_ff;
  reg  [7:0] reload_high_ff;
  reg  [7:0] nxt_ctrl;
  reg  [7:0] nxt_count_low;
  reg  [7:0] nxt_count_high;
  reg  [7:0] nxt_reload_low;
  reg  [7:0] nxt_reload_high;
  reg        ext_tick;
  reg        cap_tick;
  reg        set_high;
  reg        set_low;
  wire       div12_pulse;
  wire       rtc8_pulse;
  wire       cmp_pulse;
  wire       high_flag;
  wire       low_flag;
  wire       low_byte_irq_enable;
  wire       capture_enable;
  wire       split_mode_select;
  wire       run_control;
  wire [1:0] source_select;
  wire       tick_low;
  wire       tick_high;
  wire       run_low;
  wire       run_high;
  wire       low_wrap;
  wire       high_wrap;
  wire       full_wrap;

  // ----------------------------------------
  // Field aliases
  // ----------------------------------------
  assign high_flag           = timer_control_reg_ff[`TMC_BIT_HIGH_FLAG];
  assign low_flag            = timer_control_reg_ff[`TMC_BIT_LOW_FLAG];
  assign low_byte_irq_enable = timer_control_reg_ff[`TMC_BIT_LOW_IRQEN];
  assign capture_enable      = timer_control_reg_ff[`TMC_BIT_CAPTURE];
  assign split_mode_select   = timer_control_reg_ff[`TMC_BIT_SPLIT];
  assign run_control         = timer_control_reg_ff[`TMC_BIT_RUN];
  assign source_select       = {timer_control_reg_ff[`TMC_BIT_SRC_HI],
                                timer_control_reg_ff[`TMC_BIT_SRC_LO]};

  // Write-decode helper
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // Source enables
  // ----------------------------------------
  tmc_srcgen u_srcgen (
    .core_clk       (core_clk),
    .arst_n         (arst_n),
    .rtc_clk_in     (rtc_clk_in),
    .cmp0_in        (cmp0_in),
    .div12_pulse_ff (div12_pulse),
    .rtc8_pulse_ff  (rtc8_pulse),
    .cmp_pulse_ff   (cmp_pulse)
  );

  // Source decode
  always @* begin
    case (source_select)
      2'b00: begin
        ext_tick = div12_pulse;
        cap_tick = rtc8_pulse;
      end
      2'b01: begin
        ext_tick = cmp_pulse;
        cap_tick = rtc8_pulse;
      end
      2'b10: begin
        ext_tick = div12_pulse;
        cap_tick = cmp_pulse;
      end
      default: begin
        ext_tick = rtc8_pulse;
        cap_tick = cmp_pulse;
      end
    endcase
  end

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // Per-byte pick between system clock and shared source
  assign tick_low  = low_byte_clock_pick  ? 1'b1 : ext_tick;
  assign tick_high = high_byte_clock_pick ? 1'b1 : ext_tick;
  // Low byte free-runs in split mode
  assign run_low   = split_mode_select ? tick_low
                                       : (run_control && tick_low);
  assign run_high  = run_control && tick_high;
  assign low_wrap  = run_low && (count_low_ff == 8'hFF);
  assign high_wrap = run_high && (count_high_ff == 8'hFF);
  assign full_wrap = low_wrap && (count_high_ff == 8'hFF);

  always @* begin
    nxt_count_low   = count_low_ff;
    nxt_count_high  = count_high_ff;
    nxt_reload_low  = reload_low_ff;
    nxt_reload_high = reload_high_ff;
    set_high        = 1'b0;
    set_low         = low_wrap;
    if (split_mode_select) begin
      if (run_low) begin
        nxt_count_low = low_wrap ? reload_low_ff : count_low_ff + 8'd1;
      end
      if (run_high) begin
        nxt_count_high = high_wrap ? reload_high_ff
                                   : count_high_ff + 8'd1;
      end
      set_high = high_wrap;
    end else if (run_low) begin
      if (full_wrap && !capture_enable) begin
        nxt_count_low  = reload_low_ff;
        nxt_count_high = reload_high_ff;
      end else begin
        nxt_count_low = count_low_ff + 8'd1;
        if (low_wrap) begin
          nxt_count_high = count_high_ff + 8'd1;
        end
      end
      set_high = full_wrap;
    end
    // Capture mode: trigger copies count into reload pair
    if (capture_enable && run_control && cap_tick) begin
      nxt_reload_low  = count_low_ff;
      nxt_reload_high = count_high_ff;
      set_high        = 1'b1;
    end
    // Software writes to data registers
    if (wr_hit(sfr_addr, `TMC_ADDR_COUNT_LO, sfr_wr)) begin
      nxt_count_low = sfr_wdata;
    end
    if (wr_hit(sfr_addr, `TMC_ADDR_COUNT_HI, sfr_wr)) begin
      nxt_count_high = sfr_wdata;
    end
    if (wr_hit(sfr_addr, `TMC_ADDR_RELOAD_LO, sfr_wr)) begin
      nxt_reload_low = sfr_wdata;
    end
    if (wr_hit(sfr_addr, `TMC_ADDR_RELOAD_HI, sfr_wr)) begin
      nxt_reload_high = sfr_wdata;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @* begin
    nxt_ctrl = timer_control_reg_ff;
    if (wr_hit(sfr_addr, `TMC_ADDR_CTRL, sfr_wr)) begin
      nxt_ctrl = sfr_wdata;
    end else if (wr_hit(sfr_addr, `TMC_ADDR_CTRL, sfr_bit_wr)) begin
      nxt_ctrl[sfr_bit_sel] = sfr_bit_val;
    end
    // Flags only ever cleared by software, and hardware set wins
    if (set_high) begin
      nxt_ctrl[`TMC_BIT_HIGH_FLAG] = 1'b1;
    end
    if (set_low) begin
      nxt_ctrl[`TMC_BIT_LOW_FLAG] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_reg_ff <= `TMC_RST_CTRL;
      count_low_ff         <= `TMC_RST_BYTE;
      count_high_ff        <= `TMC_RST_BYTE;
      reload_low_ff        <= `TMC_RST_BYTE;
      reload_high_ff       <= `TMC_RST_BYTE;
      timer_irq_ff         <= 1'b0;
      sfr_rdata_ff         <= 8'h00;
    end else begin
      timer_control_reg_ff <= nxt_ctrl;
      count_low_ff         <= nxt_count_low;
      count_high_ff        <= nxt_count_high;
      reload_low_ff        <= nxt_reload_low;
      reload_high_ff       <= nxt_reload_high;
      // Level request while an enabled flag stands
      timer_irq_ff <= timer_irq_enable &&
                      (nxt_ctrl[`TMC_BIT_HIGH_FLAG] ||
                       (nxt_ctrl[`TMC_BIT_LOW_IRQEN] &&
                        nxt_ctrl[`TMC_BIT_LOW_FLAG]));
      // Registered read data
      if (sfr_addr == `TMC_ADDR_CTRL) begin
        sfr_rdata_ff <= timer_control_reg_ff;
      end else if (sfr_addr == `TMC_ADDR_RELOAD_LO) begin
        sfr_rdata_ff <= reload_low_ff;
      end else if (sfr_addr == `TMC_ADDR_RELOAD_HI) begin
        sfr_rdata_ff <= reload_high_ff;
      end else if (sfr_addr == `TMC_ADDR_COUNT_LO) begin
        sfr_rdata_ff <= count_low_ff;
      end else if (sfr_addr == `TMC_ADDR_COUNT_HI) begin
        sfr_rdata_ff <= count_high_ff;
      end else begin
        sfr_rdata_ff <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

/* dv/tmc_timer_monitor.sv */
// Port checker for the timer 2 control block
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_monitor (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Register port and request
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic       sfr_bit_val,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic       timer_irq_enable,
  input wire logic       timer_irq_ff
);
  wire c8 = sfr_addr == 8'hC8;
  wire rd = c8 && !sfr_wr && !sfr_bit_wr;
  wire bset = sfr_bit_wr && !sfr_wr && c8;
  // ------
  // Properties
  // ------
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_reset_clear: assert property (
    $rose(arst_n) |-> sfr_rdata_ff == 8'h00) else $error("Read not zero");
  a_irq_off: assert property (
    !timer_irq_enable |=> !timer_irq_ff) else $error("Request while off");
  a_irq_level: assert property (c8 |=>
    $past(timer_irq_ff) == ($past(timer_irq_enable, 2) && (sfr_rdata_ff[7]
    || sfr_rdata_ff[6] && sfr_rdata_ff[5]))) else $error("Bad request");
  a_byte_rw: assert property (sfr_wr && c8 ##1 rd |=>
    ((sfr_rdata_ff ^ $past(sfr_wdata, 2)) & 8'h3F) == 8'h00)
    else $error("Byte write lost");
  a_bit_rw: assert property (bset && sfr_bit_sel < 3'h6 ##1 rd |=>
    sfr_rdata_ff[$past(sfr_bit_sel, 2)] == $past(sfr_bit_val, 2))
    else $error("Bit write lost");
  a_flag_soft_set: assert property (
    bset && sfr_bit_sel[2:1] == 2'b11 && sfr_bit_val ##1 rd |=>
    sfr_rdata_ff[$past(sfr_bit_sel, 2)]) else $error("Flag set lost");
  a_flag_hold: assert property (rd ##1 c8 |=>
    (~sfr_rdata_ff & $past(sfr_rdata_ff) & 8'hC0) == 8'h00)
    else $error("Flag cleared by hardware");
  a_unmapped_zero: assert property (
    sfr_addr != 8'hC8 && (sfr_addr < 8'hCA || sfr_addr > 8'hCD) |=>
    sfr_rdata_ff == 8'h00) else $error("Unmapped read not zero");
  c_irq_rise: cover property ($rose(timer_irq_ff));
  c_both_flags: cover property (rd ##1 sfr_rdata_ff[7:6] == 2'b11);
  c_bit_write: cover property (bset ##1 rd);
endmodule
bind tmc_timer tmc_timer_monitor tmc_timer_monitor_inst (
  .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
  .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
  .sfr_rdata_ff(sfr_rdata_ff), .timer_irq_enable(timer_irq_enable),
  .timer_irq_ff(timer_irq_ff));
`default_nettype wire

/* dv/timer2_control_status_tb.sv */
// Self-checking bench for the timer 2 control block
`timescale 1ns/1ns
`default_nettype none
module timer2_control_status_tb;
  logic        core_clk = 1'b0, arst_n = 1'b0;
  logic  [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  logic  [2:0] sfr_bit_sel = 3'h0;
  logic        pick_hi = 1'b0, pick_lo = 1'b0, irq_en = 1'b0;
  logic        rtc_clk_in = 1'b0, cmp0_in = 1'b0;
  wire   [7:0] sfr_rdata_ff;
  wire         timer_irq_ff;
  int          num_errors = 0, checked = 0, i, s;
  logic [23:0] rows [0:7] = '{24'hCA5A5A, 24'hCBA5A5, 24'hCC1212,
    24'hCD3434, 24'hC83B3B, 24'hC80000, 24'hC9FF00, 24'hCEFF00};
  tmc_timer tmc_timer_inst (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
    .sfr_rdata_ff(sfr_rdata_ff), .high_byte_clock_pick(pick_hi),
    .low_byte_clock_pick(pick_lo), .timer_irq_enable(irq_en),
    .rtc_clk_in(rtc_clk_in), .cmp0_in(cmp0_in),
    .timer_irq_ff(timer_irq_ff));
  always #5 core_clk = ~core_clk;
  // ------
  // Bus tasks
  // ------
  task automatic cyc(input logic [7:0] a, d, input logic w, b,
                     input logic [2:0] bs, input logic bv);
    {sfr_addr, sfr_wdata, sfr_wr, sfr_bit_wr, sfr_bit_sel, sfr_bit_val}
      <= {a, d, w, b, bs, bv};
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    cyc(a, d, 1'b1, 1'b0, 3'h0, 1'b0);
  endtask
  task automatic seq(input logic [127:0] q, input int n);
    for (int k = n - 1; k >= 0; k--) wr(q[k*16+8 +: 8], q[k*16 +: 8]);
  endtask
  task automatic bw(input logic [2:0] bs, input logic bv);
    cyc(8'hC8, 8'h00, 1'b0, 1'b1, bs, bv);
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(8'h00, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0);
  endtask
  task automatic chk(input string n, input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, exp, input string n);
    cyc(a, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0);
    #1 chk(n, sfr_rdata_ff, exp);
  endtask
  task automatic fire(input logic rtc);
    repeat (rtc ? 8 : 1) begin
      {rtc_clk_in, cmp0_in} <= {rtc, !rtc};
      idle(3);
      {rtc_clk_in, cmp0_in} <= 2'b00;
      idle(3);
    end
    idle(6);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 5; i++) rchk(i ? 8'(8'hC9 + i) : 8'hC8, 8'h00, "rst");
    $display("Reset test done");
    for (i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0], "row");
    end
    $display("Register rows done");
    {pick_lo, irq_en} <= 2'b11;
    seq({16'hCD00, 16'hCCFE, 16'hC804}, 3);
    idle(4);
    rchk(8'hC8, 8'h44, "low wrap only");
    chk("irq", {7'h00, timer_irq_ff}, 8'h00);
    bw(3'h5, 1'b1);
    rchk(8'hC8, 8'h64, "low irq enable");
    chk("irq", {7'h00, timer_irq_ff}, 8'h01);
    bw(3'h6, 1'b0);
    rchk(8'hC8, 8'h24, "low clear");
    bw(3'h7, 1'b1);
    rchk(8'hC8, 8'hA4, "high set");
    seq({16'hC800, 16'hCB12, 16'hCA34, 16'hCDFF, 16'hCCFF, 16'hC804}, 6);
    wr(8'hC8, 8'h04);
    rchk(8'hC8, 8'hC4, "set beats write");
    chk("irq", {7'h00, timer_irq_ff}, 8'h01);
    rchk(8'hCD, 8'h12, "reload high");
    seq({16'hC800, 16'hCC77}, 2);
    idle(5);
    rchk(8'hCC, 8'h77, "stopped hold");
    $display("Sixteen-bit test done");
    pick_hi <= 1'b1;
    seq({16'hCAF0, 16'hCB00, 16'hCDFE, 16'hCCFE, 16'hC808}, 5);
    idle(4);
    rchk(8'hCD, 8'hFE, "high held");
    rchk(8'hC8, 8'h48, "split low wrap");
    wr(8'hC8, 8'h0C);
    idle(20);
    rchk(8'hC8, 8'hCC, "split high wrap");
    rchk(8'hC8, 8'hCC, "flags kept");
    $display("Split test done");
    wr(8'hC8, 8'h00);
    for (s = 0; s < 4; s++) begin
      seq({16'hCBFF, 16'hCD00, 16'hCC00, 8'hC8, 8'(8'h14 + s)}, 4);
      fire(s >= 2);
      rchk(8'hCB, 8'hFF, "wrong trigger");
      fire(s < 2);
      rchk(8'hCB, 8'h00, "capture value");
      rchk(8'hC8, 8'(8'h94 + s), "capture flag");
    end
    irq_en <= 1'b0;
    rchk(8'hC8, 8'h97, "flag stays");
    chk("irq off", {7'h00, timer_irq_ff}, 8'h00);
    pick_lo <= 1'b0;
    seq({16'hC800, 16'hCC00, 16'hC805}, 3);
    fire(1'b1);
    fire(1'b0);
    rchk(8'hCC, 8'h01, "external tick");
    $display("Source test done");
    print_verdict;
  end
  initial begin
    #900000;
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
